/* rtl/pmtr_core.v */
// program memory, vectors, table read path and data memory map
`timescale 1ns/1ns
`include "pmtr_defines.vh"
module pmtr_core #(
  parameter PAW = `PMTR_PROG_AW,
  parameter PDW = `PMTR_PROG_DW,
  parameter RAW = `PMTR_RAM_AW
) (
  // clock and reset
  input wire clock,
  input wire nrst,
  // program store loading
  input wire prog_we,
  input wire [PAW-1:0] prog_addr,
  input wire [PDW-1:0] prog_data,
  // control from core execution logic
  input wire instr_step,
  input wire branch_req,
  input wire [PAW-1:0] branch_addr,
  input wire tab_rd_cur,
  input wire tab_rd_last,
  input wire [RAW-1:0] tab_dest,
  // interrupt requests and enables
  input wire ext_irq,
  input wire tmr_irq,
  input wire tb_irq,
  input wire adc_irq,
  input wire [3:0] irq_en,
  input wire stack_full,
  // data memory access from core
  input wire dm_we,
  input wire dm_bit_set,
  input wire dm_bit_clr,
  input wire [2:0] dm_bit_sel,
  input wire [RAW-1:0] dm_addr,
  input wire [7:0] dm_wdata,
  input wire dm_re,
  // outputs
  output reg [PAW-1:0] pc_r,
  output reg [PDW-1:0] instr_r,
  output reg instr_valid_r,
  output reg [7:0] dm_rdata_r,
  output reg [7:0] table_high_byte_r,
  output reg [7:0] table_pointer_r,
  output reg [1:0] irq_ack_r,
  output reg irq_taken_r,
  output reg tab_busy_r
);
  // fsm states
  localparam ST_FETCH = 3'b001;
  localparam ST_TAB1 = 3'b010;
  localparam ST_TAB2 = 3'b100;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [PAW-1:0] pc_nxt;
  reg [PAW-1:0] tab_addr_r;
  reg [RAW-1:0] tab_dest_r;
  reg [7:0] indirect_pointer_zero_r;
  reg [7:0] indirect_pointer_one_r;
  reg ext_s1_r;
  reg ext_s2_r;
  reg ext_s3_r;
  reg started_r;
  wire [PDW-1:0] store_q;
  wire [7:0] ram_q;
  wire ext_edge;
  wire [3:0] irq_pend;
  wire irq_go;
  reg [PAW-1:0] irq_vec;
  reg [1:0] irq_id;
  reg [PAW-1:0] rd_addr;
  reg [RAW-1:0] eff_addr;
  reg eff_null;
  reg [7:0] rd_val;
  reg [7:0] wr_val;
  reg ram_we;
  wire [PAW-1:0] tab_addr_nxt;
  reg ext_flag_r;
  wire ptr0_on_win;
  wire ptr1_on_win;
  reg ram_wr_en;
  reg [RAW-1:0] ram_wr_addr;
  reg [7:0] ram_wr_data;

  // external pin synchroniser and both-edge detection
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else begin
      ext_s1_r <= ext_irq;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  assign ext_edge = ext_s2_r ^ ext_s3_r;

  // pending requests gated by their enables
  assign irq_pend[0] = ext_flag_r & irq_en[0];
  assign irq_pend[1] = tmr_irq & irq_en[1];
  assign irq_pend[2] = tb_irq & irq_en[2];
  assign irq_pend[3] = adc_irq & irq_en[3];
  // a full return stack holds every request back; vectoring only on a fetch step
  assign irq_go = (|irq_pend) & ~stack_full & instr_step & (state_r == ST_FETCH) & started_r;

  // the edge flag keeps a pin edge until it is vectored, so a step-less cycle cannot lose it
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ext_flag_r <= 1'b0;
    end else if (ext_edge) begin
      ext_flag_r <= 1'b1;
    end else if (irq_go && (irq_id == 2'h0)) begin
      ext_flag_r <= 1'b0;
    end
  end

  // vector selection, lowest vector first
  always @* begin
    irq_vec = `PMTR_VEC_EXT;
    irq_id = 2'h0;
    if (irq_pend[0]) begin
      irq_vec = `PMTR_VEC_EXT;
      irq_id = 2'h0;
    end else if (irq_pend[1]) begin
      irq_vec = `PMTR_VEC_TMR;
      irq_id = 2'h1;
    end else if (irq_pend[2]) begin
      irq_vec = `PMTR_VEC_TB;
      irq_id = 2'h2;
    end else if (irq_pend[3]) begin
      irq_vec = `PMTR_VEC_ADC;
      irq_id = 2'h3;
    end
  end

  // table address formation
  assign tab_addr_nxt = {(tab_rd_last ? `PMTR_LAST_PAGE : pc_r[10:8]), table_pointer_r};

  // program counter and table fsm next state
  always @* begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    case (state_r)
      ST_FETCH: begin
        if (irq_go) begin
          pc_nxt = irq_vec;
        end else if (instr_step && branch_req) begin
          pc_nxt = branch_addr;
        end else if (instr_step && (tab_rd_cur || tab_rd_last)) begin
          state_nxt = ST_TAB1;
        end else if (instr_step) begin
          pc_nxt = pc_r + 11'h001;
        end
      end
      ST_TAB1: begin
        if (instr_step) begin
          state_nxt = ST_TAB2;
        end
      end
      ST_TAB2: begin
        state_nxt = ST_FETCH;
        pc_nxt = pc_r + 11'h001;
      end
      default: begin
        state_nxt = ST_FETCH;
      end
    endcase
  end

  // program store port: table address in first table cycle, else next program counter
  always @* begin
    if (state_r == ST_TAB1) begin
      rd_addr = tab_addr_r;
    end else begin
      rd_addr = pc_nxt;
    end
  end

  pmtr_prog_store #(
    .AW(PAW),
    .DW(PDW)
  ) u_store (
    .clock(clock),
    .prog_we(prog_we),
    .prog_addr(prog_addr),
    .prog_data(prog_data),
    .rd_addr(rd_addr),
    .rd_data(store_q)
  );

  // a pointer that names a window location itself reaches no storage
  assign ptr0_on_win = (indirect_pointer_zero_r[RAW-1:0] == `PMTR_ADDR_WIN0) ||
    (indirect_pointer_zero_r[RAW-1:0] == `PMTR_ADDR_WIN1);
  assign ptr1_on_win = (indirect_pointer_one_r[RAW-1:0] == `PMTR_ADDR_WIN0) ||
    (indirect_pointer_one_r[RAW-1:0] == `PMTR_ADDR_WIN1);

  // indirect redirection and data memory read mux
  always @* begin
    eff_addr = dm_addr;
    eff_null = 1'b0;
    if (dm_addr == `PMTR_ADDR_WIN0) begin
      eff_addr = indirect_pointer_zero_r[RAW-1:0];
      eff_null = ptr0_on_win;
    end else if (dm_addr == `PMTR_ADDR_WIN1) begin
      eff_addr = indirect_pointer_one_r[RAW-1:0];
      eff_null = ptr1_on_win;
    end
    case (eff_addr)
      `PMTR_ADDR_PTR0: rd_val = indirect_pointer_zero_r;
      `PMTR_ADDR_PTR1: rd_val = indirect_pointer_one_r;
      `PMTR_ADDR_PCL: rd_val = pc_r[7:0];
      `PMTR_ADDR_TBLP: rd_val = table_pointer_r;
      `PMTR_ADDR_TABLE_HIGH_BYTE: rd_val = table_high_byte_r;
      default: begin
        if (eff_addr >= `PMTR_GP_BASE) begin
          rd_val = ram_q;
        end else begin
          rd_val = 8'h00;
        end
      end
    endcase
    if (eff_null) begin
      rd_val = 8'h00;
    end
  end

  // write value: whole byte or single bit set/clear
  always @* begin
    wr_val = dm_wdata;
    if (dm_bit_set) begin
      wr_val = rd_val | (8'h01 << dm_bit_sel);
    end else if (dm_bit_clr) begin
      wr_val = rd_val & ~(8'h01 << dm_bit_sel);
    end
    ram_we = (dm_we || dm_bit_set || dm_bit_clr) && !eff_null && (eff_addr >= `PMTR_GP_BASE);
  end

  // ram write port: the second table cycle owns it, else the data access
  always @* begin
    ram_wr_en = ram_we;
    ram_wr_addr = eff_addr;
    ram_wr_data = wr_val;
    if (state_r == ST_TAB2) begin
      ram_wr_en = 1'b1;
      ram_wr_addr = tab_dest_r;
      ram_wr_data = store_q[7:0];
    end
  end

  pmtr_data_ram #(
    .AW(RAW)
  ) u_ram (
    .clock(clock),
    .we(ram_wr_en),
    .waddr(ram_wr_addr),
    .wdata(ram_wr_data),
    .raddr(eff_addr),
    .rdata(ram_q)
  );

  // vector acknowledge outputs: irq_taken_r pulses once per vector taken, irq_ack_r holds that vector's id
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irq_ack_r <= 2'h0;
      irq_taken_r <= 1'b0;
    end else begin
      irq_taken_r <= irq_go;
      if (irq_go) begin
        irq_ack_r <= irq_id;
      end
    end
  end

  // state, program counter, special registers
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_FETCH;
      pc_r <= `PMTR_VEC_RESET;
      started_r <= 1'b0;
      tab_addr_r <= {PAW{1'b0}};
      tab_dest_r <= {RAW{1'b0}};
      table_pointer_r <= 8'h00;
      table_high_byte_r <= 8'h00;
      indirect_pointer_zero_r <= 8'h00;
      indirect_pointer_one_r <= 8'h00;
      instr_r <= {PDW{1'b0}};
      instr_valid_r <= 1'b0;
      dm_rdata_r <= 8'h00;
      tab_busy_r <= 1'b0;
    end else begin
      started_r <= 1'b1;
      state_r <= state_nxt;
      pc_r <= started_r ? pc_nxt : `PMTR_VEC_RESET;
      tab_busy_r <= (state_nxt != ST_FETCH);
      instr_valid_r <= (state_r == ST_FETCH) && started_r;
      if (state_r == ST_FETCH) begin
        instr_r <= store_q;
      end
      if (state_r == ST_FETCH && instr_step && (tab_rd_cur || tab_rd_last)) begin
        tab_addr_r <= tab_addr_nxt;
        tab_dest_r <= tab_dest;
      end
      if (state_r == ST_TAB2) begin
        table_high_byte_r <= {2'h0, store_q[13:8]};
      end
      if (dm_re) begin
        dm_rdata_r <= rd_val;
      end
      if ((dm_we || dm_bit_set || dm_bit_clr) && !eff_null) begin
        // table high byte has no write path
        case (eff_addr)
          `PMTR_ADDR_PTR0: indirect_pointer_zero_r <= wr_val;
          `PMTR_ADDR_PTR1: indirect_pointer_one_r <= wr_val;
          `PMTR_ADDR_TBLP: table_pointer_r <= wr_val;
          default: table_pointer_r <= table_pointer_r;
        endcase
      end
    end
  end
endmodule // pmtr_core

/* rtl/pmtr_data_ram.v */
// 8-bit general purpose data ram, synchronous write, asynchronous read
`timescale 1ns/1ns
`include "pmtr_defines.vh"
module pmtr_data_ram #(
  parameter AW = `PMTR_RAM_AW
) (
  // clock
  input wire clock,
  // write port
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [7:0] wdata,
  // read port
  input wire [AW-1:0] raddr,
  output wire [7:0] rdata
);
  reg [7:0] mem [0:(1<<AW)-1];

  // byte wide storage
  always @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];
endmodule // pmtr_data_ram

/* rtl/pmtr_defines.vh */
// constants for the program memory and table read block
`ifndef PMTR_DEFINES_VH
`define PMTR_DEFINES_VH
`define PMTR_PROG_DEPTH 2048
`define PMTR_PROG_AW 11
`define PMTR_PROG_DW 14
`define PMTR_VEC_RESET 11'h000
`define PMTR_VEC_EXT 11'h004
`define PMTR_VEC_TMR 11'h008
`define PMTR_VEC_TB 11'h00c
`define PMTR_VEC_ADC 11'h010
`define PMTR_LAST_PAGE 3'h7
`define PMTR_RAM_DEPTH 128
`define PMTR_RAM_AW 7
`define PMTR_GP_BASE 7'h28
`define PMTR_ADDR_WIN0 7'h00
`define PMTR_ADDR_PTR0 7'h01
`define PMTR_ADDR_WIN1 7'h02
`define PMTR_ADDR_PTR1 7'h03
`define PMTR_ADDR_PCL 7'h06
`define PMTR_ADDR_TBLP 7'h07
`define PMTR_ADDR_TABLE_HIGH_BYTE 7'h08
`define PMTR_CYC_PER_INSTR 2'h3
`endif

/* rtl/pmtr_prog_store.v */
// 2048 x 14 one-time-programmable program store, synchronous read
`timescale 1ns/1ns
`include "pmtr_defines.vh"
module pmtr_prog_store #(
  parameter AW = `PMTR_PROG_AW,
  parameter DW = `PMTR_PROG_DW
) (
  // clock
  input wire clock,
  // programming port
  input wire prog_we,
  input wire [AW-1:0] prog_addr,
  input wire [DW-1:0] prog_data,
  // read port
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // programming writes and registered reads
  always @(posedge clock) begin
    if (prog_we) begin
      mem[prog_addr] <= prog_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // pmtr_prog_store

/* tb/pmtr_core_asserts.sv */
// port assertions for the program memory and table read block
`timescale 1ns/1ns
module pmtr_core_asserts (
  // clock and reset
  input wire clock, input wire nrst,
  // core requests
  input wire instr_step, input wire branch_req, input wire tab_rd_cur, input wire tab_rd_last,
  input wire [3:0] irq_en, input wire stack_full,
  // data memory access
  input wire dm_we, input wire dm_re, input wire [6:0] dm_addr, input wire [7:0] dm_wdata,
  // results
  input wire [10:0] pc_r, input wire [1:0] irq_ack_r, input wire irq_taken_r, input wire tab_busy_r,
  input wire [7:0] table_high_byte_r, input wire [7:0] table_pointer_r, input wire [7:0] dm_rdata_r
);
  reg [3:0] en_q_r;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // enables as they stood at the deciding edge
  always @(posedge clock) en_q_r <= irq_en;
  property p_rst_pc; $rose(nrst) |-> pc_r == 11'h000; endproperty
  a_rst_pc: assert property (p_rst_pc) else $error("pc not zero");
  property p_vec; irq_taken_r |-> pc_r == ({9'h000, irq_ack_r} + 11'h001) << 2; endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_full; $past(stack_full) |-> !irq_taken_r; endproperty
  a_full: assert property (p_full) else $error("vector on full stack");
  property p_en; irq_taken_r |-> en_q_r[irq_ack_r]; endproperty
  a_en: assert property (p_en) else $error("vector while disabled");
  property p_hi_zero; table_high_byte_r[7:6] == 2'h0; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("high byte top bits");
  property p_hi_ro; !tab_busy_r && !$past(tab_busy_r) |-> $stable(table_high_byte_r); endproperty
  a_hi_ro: assert property (p_hi_ro) else $error("high byte changed");
  property p_tp; dm_we && dm_addr == 7'h07 |=> table_pointer_r == $past(dm_wdata); endproperty
  a_tp: assert property (p_tp) else $error("pointer not loaded");
  property p_unused; dm_re && dm_addr == 7'h04 |=> dm_rdata_r == 8'h00; endproperty
  a_unused: assert property (p_unused) else $error("unused not zero");
  property p_inc; instr_step && !branch_req && !tab_rd_cur && !tab_rd_last && !tab_busy_r
    |=> pc_r == $past(pc_r) + 11'h001 || irq_taken_r; endproperty
  a_inc: assert property (p_inc) else $error("pc not advanced");
  property p_start; instr_step && (tab_rd_cur || tab_rd_last) && !tab_busy_r && !branch_req
    |=> tab_busy_r || irq_taken_r; endproperty
  a_start: assert property (p_start) else $error("table read not begun");
  property p_end; $rose(tab_busy_r) |-> ##[1:40] !tab_busy_r; endproperty
  a_end: assert property (p_end) else $error("table read too long");
  property p_hold; tab_busy_r && $past(tab_busy_r) |-> $stable(pc_r); endproperty
  a_hold: assert property (p_hold) else $error("fetch during table");
endmodule // pmtr_core_asserts
bind pmtr_core pmtr_core_asserts pmtr_core_asserts_inst (.*);

/* tb/pmtr_core_tb.sv */
// self-checking bench for the program memory and table read block
`timescale 1ns/1ns
module pmtr_core_tb;
  reg clock = 0, nrst = 0, prog_we = 0, branch_req = 0, tab_rd_cur = 0, tab_rd_last = 0, stack_full = 0;
  reg ext_irq = 0, tmr_irq = 0, tb_irq = 0, adc_irq = 0, dm_we = 0, dm_bit_set = 0, dm_bit_clr = 0, dm_re = 0;
  reg run = 0, seen = 0;
  reg [10:0] prog_addr = 0, branch_addr = 0;
  reg [13:0] prog_data = 0;
  reg [6:0] tab_dest = 0, dm_addr = 0;
  reg [7:0] dm_wdata = 0, v = 0;
  reg [3:0] irq_en = 0;
  reg [2:0] dm_bit_sel = 0;
  reg [1:0] gap = 2;
  wire instr_step, instr_valid_r, irq_taken_r, tab_busy_r;
  wire [10:0] pc_r;
  wire [13:0] instr_r;
  wire [7:0] dm_rdata_r, table_high_byte_r, table_pointer_r;
  wire [1:0] irq_ack_r;
  int n_errors = 0, n_compared = 0, k, i, j, a;
  int pm[2048];
  int tp[8];
  pmtr_core pmtr_core_inst (.*);
  pmtr_step_model pmtr_step_model_inst (.*);
  // 100 MHz clock
  initial begin
    forever #5 clock = ~clock;
  end
  task chk(input [15:0] s, input [15:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // bounded wait: 0 busy, 1 idle, 2 vector taken, 3 branch landed
  task wt(input int w);
    for (k = 0; k < 300; k++) begin
      @(posedge clock);
      #1;
      if (w == 0 ? tab_busy_r === 1 : w == 1 ? tab_busy_r === 0 : w == 2 ? irq_taken_r === 1 : pc_r === branch_addr)
        return;
    end
    n_errors++;
    complete_run;
  endtask
  // one data access, op is {read, clear, set, write}
  task dm(input [3:0] op, input [2:0] s, input [6:0] ad, input [7:0] d);
    @(posedge clock);
    {dm_re, dm_bit_clr, dm_bit_set, dm_we} <= op;
    dm_bit_sel <= s;
    dm_addr <= ad;
    dm_wdata <= d;
    @(posedge clock);
    {dm_re, dm_bit_clr, dm_bit_set, dm_we} <= 4'h0;
    #1;
  endtask
  task rd(input [6:0] ad, input [7:0] e);
    dm(8, 0, ad, 0);
    chk(dm_rdata_r, e);
  endtask
  task br(input [10:0] t);
    @(posedge clock);
    branch_req <= 1;
    branch_addr <= t;
    wt(3);
    @(posedge clock);
    branch_req <= 0;
    #1;
    chk(instr_r, pm[t]);
    chk(instr_valid_r, 1);
  endtask
  // table read against the word model
  task trd(input bit last, input [7:0] p, input [6:0] d);
    dm(1, 0, 7, p);
    chk(table_pointer_r, p);
    a = {(last ? 3'h7 : pc_r[10:8]), p};
    @(posedge clock);
    tab_rd_last <= last;
    tab_rd_cur <= !last;
    tab_dest <= d;
    wt(0);
    @(posedge clock);
    tab_rd_last <= 0;
    tab_rd_cur <= 0;
    wt(1);
    chk(table_high_byte_r, pm[a] >> 8);
    rd(d, pm[a] % 256);
  endtask
  // main sequence
  initial begin
    v = $urandom(32'h2439);
    repeat (10) @(posedge clock);
    nrst <= 1;
    @(posedge clock);
    #1;
    chk(pc_r, 0);
    // table words in the last page and page 3, then the branch target word
    for (i = 0; i < 17; i++) begin
      if (i < 8) tp[i] = $urandom % 256;
      a = (i == 16) ? 11'h340 : {(i < 8 ? 3'h7 : 3'h3), 8'(tp[i % 8])};
      pm[a] = $urandom % 16384;
      @(posedge clock);
      prog_we <= 1;
      prog_addr <= 11'(a);
      prog_data <= 14'(pm[a]);
    end
    @(posedge clock);
    prog_we <= 0;
    run <= 1;
    irq_en <= 0;
    for (i = 0; i < 8; i++) begin
      gap <= (i < 4) ? 2'h0 : 2'h3;
      if (i == 4) br(11'h340);
      trd(i < 4, 8'(tp[i]), 7'(7'h30 + i));
    end
    $display("table test done");
    rd(7'h04, 0);
    v = table_high_byte_r;
    dm(1, 0, 7'h08, ~v);
    chk(table_high_byte_r, v);
    rd(7'h08, v);
    dm(1, 0, 7'h01, 8'h40);
    dm(1, 0, 7'h03, 8'h7f);
    dm(1, 0, 7'h00, 8'h5a);
    dm(1, 0, 7'h02, 8'ha5);
    rd(7'h40, 8'h5a);
    rd(7'h02, 8'ha5);
    rd(7'h7f, 8'ha5);
    dm(2, 5, 7'h40, 0);
    rd(7'h40, 8'h7a);
    dm(4, 3, 7'h40, 0);
    rd(7'h40, 8'h72);
    v = $urandom;
    dm(1, 0, 7'h28, v);
    rd(7'h28, v);
    $display("data test done");
    gap <= 2;
    for (i = 0; i < 5; i++) begin
      j = i % 4;
      @(posedge clock);
      irq_en <= 4'h1 << j;
      {adc_irq, tb_irq, tmr_irq} <= 3'((4'h1 << j) >> 1);
      if (j == 0) ext_irq <= ~ext_irq;
      wt(2);
      chk(pc_r, 4 * (j + 1));
      chk(irq_ack_r, j);
      @(posedge clock);
      irq_en <= 0;
      {adc_irq, tb_irq, tmr_irq} <= 3'h0;
      repeat (6) @(posedge clock);
    end
    $display("vector test done");
    @(posedge clock);
    stack_full <= 1;
    irq_en <= 4'h2;
    tmr_irq <= 1;
    repeat (30) begin
      @(posedge clock);
      #1;
      seen = seen | (irq_taken_r === 1);
    end
    chk(seen, 0);
    @(posedge clock);
    stack_full <= 0;
    wt(2);
    chk(pc_r, 11'h008);
    @(posedge clock);
    tmr_irq <= 0;
    irq_en <= 0;
    nrst <= 0;
    repeat (2) @(posedge clock);
    #1;
    chk(pc_r, 0);
    @(posedge clock);
    nrst <= 1;
    @(posedge clock);
    #1;
    chk(pc_r, 0);
    $display("refusal and reset test done");
    complete_run;
  end
endmodule // pmtr_core_tb

/* tb/pmtr_step_model.sv */
// core model that issues instruction-cycle steps
`timescale 1ns/1ns
module pmtr_step_model (
  // clock and reset
  input wire clock,
  input wire nrst,
  // pacing from the bench
  input wire run,
  input wire [1:0] gap,
  // step to the block
  output reg instr_step
);
  reg [1:0] cnt_r;
  // one step every gap+1 cycles, silent while halted
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 2'h0;
      instr_step <= 1'b0;
    end else begin
      instr_step <= run && cnt_r == gap;
      cnt_r <= (run && cnt_r != gap) ? cnt_r + 2'h1 : 2'h0;
    end
  end
endmodule // pmtr_step_model
